// [testbench/bcf_core_test.sv]
`timescale 1ns/1ps
`default_nettype none
module bcf_core_test;
    logic CLK_SYS, RESETN, INSTR_VALID, EXT_EN, MEM_RD, MEM_WR, BUSY, DONE, act, pend;
    logic [15:0] INSTR_WORD;
    logic [3:0] BANK_SELECT_REG, opc;
    logic [11:0] INDEX_BASE, MEM_ADDR, ea;
    logic [7:0] MEM_RDATA, MEM_WDATA, f;
    int n_fail = 0;
    int total_checks = 0;
    int seed = 42;
    bcf_core bcf_core_inst (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .INSTR_VALID(INSTR_VALID),
        .INSTR_WORD(INSTR_WORD), .EXT_EN(EXT_EN), .BANK_SELECT_REG(BANK_SELECT_REG),
        .INDEX_BASE(INDEX_BASE), .MEM_RDATA(MEM_RDATA), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD),
        .MEM_WR(MEM_WR), .MEM_WDATA(MEM_WDATA), .BUSY(BUSY), .DONE(DONE));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic conclude;
        if (n_fail == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        CLK_SYS = 1'b0;
        forever #50 CLK_SYS = ~CLK_SYS;
    end
    // Whole run is about 350 cycles; a hang is cut after 1000
    initial begin
        #100000;
        n_fail++;
        conclude;
    end
    initial begin
        {RESETN, INSTR_VALID, EXT_EN, pend} = 4'h0;
        {INSTR_WORD, BANK_SELECT_REG, INDEX_BASE, MEM_RDATA} = 40'h0;
        repeat (20) @(negedge CLK_SYS);
        RESETN = 1'b1;
        // Each pass is one Q1..Q4 cycle; words go in at the Q1 falling edge
        for (int i = 0; i < 80; i++) begin
            chk("done", 12'(pend), 12'(DONE));
            f = (i % 7 == 0) ? 8'h5F : (i % 7 == 1) ? 8'h60 : 8'($random(seed));
            opc = (i % 5 == 4 && i[3]) ? 4'hB : 4'h9;
            INSTR_VALID = !(i % 5 == 4 && !i[3]);
            act = INSTR_VALID && opc == 4'h9;
            pend = act;
            INSTR_WORD = {opc, 4'($random(seed)), f};
            EXT_EN = i[1];
            BANK_SELECT_REG = 4'($random(seed));
            INDEX_BASE = 12'($random(seed));
            if (INSTR_WORD[8])
                ea = {BANK_SELECT_REG, f};
            else if (EXT_EN && f <= 8'h5F)
                ea = INDEX_BASE + 12'(f);
            else
                ea = {(f >= 8'h60) ? 4'hF : 4'h0, f};
            @(negedge CLK_SYS);
            chk("rd", 12'(act), 12'(MEM_RD));
            chk("busy", 12'(act), 12'(BUSY));
            if (act)
                chk("addr", ea, MEM_ADDR);
            MEM_RDATA = 8'($random(seed));
            f = MEM_RDATA & ~(8'h01 << INSTR_WORD[11:9]);
            repeat (2) @(negedge CLK_SYS);
            chk("wr", 12'(act), 12'(MEM_WR));
            if (act)
                chk("wdata", 12'(f), 12'(MEM_WDATA));
            @(negedge CLK_SYS);
        end
        chk("done", 12'(pend), 12'(DONE));
        conclude;
    end
endmodule
`default_nettype wire

// [verilog/bcf_addr.sv]
`timescale 1ns/1ps
`default_nettype none
module bcf_addr (
    input wire logic [7:0] f,
    input wire logic acc,
    input wire logic ext_en,
    input wire logic [3:0] bank,
    input wire logic [11:0] fsr2,
    output logic [11:0] addr
);
    always_comb begin
        if (acc) begin
            addr = {bank, f};
        end else if (ext_en && f <= bcf_pkg::BCF_IDX_MAX) begin
            addr = fsr2 + {4'h0, f};
        end else if (f >= bcf_pkg::BCF_ACC_SPLIT) begin
            addr = {bcf_pkg::BCF_SFR_BANK, f};
        end else begin
            addr = {bcf_pkg::BCF_ACC_BANK, f};
        end
    end
endmodule
`default_nettype wire

// [verilog/bcf_core.sv]
`timescale 1ns/1ps
`default_nettype none
module bcf_core (
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic INSTR_VALID,
    input wire logic [15:0] INSTR_WORD,
    input wire logic EXT_EN,
    input wire logic [3:0] BANK_SELECT_REG,
    input wire logic [11:0] INDEX_BASE,
    input wire logic [7:0] MEM_RDATA,
    output logic [11:0] MEM_ADDR,
    output logic MEM_RD,
    output logic MEM_WR,
    output logic [7:0] MEM_WDATA,
    output logic BUSY,
    output logic DONE
);
    typedef struct packed {
        bcf_pkg::bcf_phase_t ph;
        logic active;
        logic [2:0] bit_idx;
        logic [11:0] addr;
        logic [7:0] data;
        logic done;
    } bcf_state_t;

    bcf_state_t s;
    bcf_state_t next_s;
    logic [11:0] dec_addr;
    logic is_bcf;
    logic acc_bit;
    logic [7:0] f_field;
    logic [7:0] clr_mask;

    ////////////////////////////////////////////////////////////////
    // Opcode match kept in one place so the decode and its checks agree
    function automatic logic bcf_match(input logic [15:0] word);
        return word[bcf_pkg::BCF_OPC_MSB -: 4] == bcf_pkg::BCF_OPC;
    endfunction

    // Field layout must keep opcode, bit index and access bit apart
    if (bcf_pkg::BCF_BIT_LSB + 3 > bcf_pkg::BCF_OPC_MSB - 3 ||
        bcf_pkg::BCF_ACC_POS >= bcf_pkg::BCF_BIT_LSB) begin : g_bad_layout
        $error("Instruction field layout overlaps");
    end

    assign is_bcf = bcf_match(INSTR_WORD);
    assign acc_bit = INSTR_WORD[bcf_pkg::BCF_ACC_POS];
    assign f_field = INSTR_WORD[7:0];

    // One gate per bit turns the clear into a plain AND mask
    for (genvar gi = 0; gi < 8; gi++) begin : g_mask
        assign clr_mask[gi] = s.bit_idx != 3'(gi);
    end

    bcf_addr u_addr (
        .f(f_field),
        .acc(acc_bit),
        .ext_en(EXT_EN),
        .bank(BANK_SELECT_REG),
        .fsr2(INDEX_BASE),
        .addr(dec_addr)
    );

    ////////////////////////////////////////////////////////////////
    // Phases advance every clock; a new word is only taken in Q1
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        unique case (s.ph)
            bcf_pkg::BCF_Q1: begin
                next_s.ph = bcf_pkg::BCF_Q2;
                next_s.active = INSTR_VALID && is_bcf;
                next_s.bit_idx = INSTR_WORD[bcf_pkg::BCF_BIT_LSB +: 3];
                next_s.addr = dec_addr;
            end
            bcf_pkg::BCF_Q2: begin
                next_s.ph = bcf_pkg::BCF_Q3;
                next_s.data = MEM_RDATA;
            end
            bcf_pkg::BCF_Q3: begin
                next_s.ph = bcf_pkg::BCF_Q4;
                next_s.data = s.data & clr_mask;
            end
            bcf_pkg::BCF_Q4: begin
                next_s.ph = bcf_pkg::BCF_Q1;
                next_s.done = s.active;
                next_s.active = 1'b0;
            end
            default: next_s.ph = bcf_pkg::BCF_Q1;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            s <= '{ph: bcf_pkg::BCF_Q1, active: 1'b0, bit_idx: 3'h0,
                   addr: bcf_pkg::BCF_ADDR_RST, data: bcf_pkg::BCF_DATA_RST, done: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////
    // No status outputs exist: flags are left untouched by construction
    assign MEM_ADDR = s.addr;
    assign MEM_WDATA = s.data;
    assign MEM_RD = s.active && s.ph == bcf_pkg::BCF_Q2;
    assign MEM_WR = s.active && s.ph == bcf_pkg::BCF_Q4;
    assign BUSY = s.active;
    assign DONE = s.done;

    ////////////////////////////////////////////////////////////////
    // Checks sample the phase register, so a word is judged only in Q1
    sequence bcf_start_s;
        s.ph == bcf_pkg::BCF_Q1 && INSTR_VALID && is_bcf;
    endsequence

    sequence bcf_skip_s;
        s.ph == bcf_pkg::BCF_Q1 && !(INSTR_VALID && bcf_match(INSTR_WORD));
    endsequence

    sequence bcf_rmw_s;
        MEM_RD ##2 MEM_WR;
    endsequence

    sequence bcf_quiet_s;
        !MEM_RD ##2 !MEM_WR ##1 !DONE;
    endsequence

    one_cycle_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        bcf_start_s |=> bcf_rmw_s ##1 DONE)
        else $error("Instruction did not finish in one cycle");

    skip_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        bcf_skip_s |=> bcf_quiet_s)
        else $error("Access made for a refused word");

    busy_span_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        bcf_start_s |=> BUSY [*3] ##1 !BUSY)
        else $error("Busy span is not three phases");

    rd_once_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        MEM_RD |=> !MEM_RD && !MEM_WR)
        else $error("Read strobe longer than one phase");

    wr_once_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        MEM_WR |=> !MEM_WR && !BUSY)
        else $error("Write strobe longer than one phase");

    wr_after_rd_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        MEM_WR |-> $past(MEM_RD, 2))
        else $error("Write without read two phases before");

    done_after_wr_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        DONE |-> $past(MEM_WR))
        else $error("Done without preceding write");

    done_pulse_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        DONE |=> !DONE)
        else $error("Done longer than one phase");

    done_busy_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        DONE |-> !BUSY)
        else $error("Busy still high with done");

    idle_quiet_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        !BUSY |-> !MEM_RD && !MEM_WR)
        else $error("Memory strobe while idle");

    rd_busy_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        $rose(BUSY) |-> MEM_RD)
        else $error("Busy did not start with a read");

    wr_busy_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        MEM_WR |-> BUSY)
        else $error("Write outside busy span");

    addr_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        BUSY && !MEM_RD |-> $stable(MEM_ADDR))
        else $error("Address moved during instruction");

    phase_onehot_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        $onehot(s.ph))
        else $error("Phase register not one-hot");

    phase_step_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        s.ph == bcf_pkg::BCF_Q1 |=> s.ph == bcf_pkg::BCF_Q2 ##1 s.ph == bcf_pkg::BCF_Q3
            ##1 s.ph == bcf_pkg::BCF_Q4 ##1 s.ph == bcf_pkg::BCF_Q1)
        else $error("Phase order broken");

    clear_bit_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        MEM_RD |=> ##1 MEM_WDATA == ($past(MEM_RDATA, 2) & ~(8'h01 << s.bit_idx)))
        else $error("Write data is not read data with bit cleared");

    target_zero_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        MEM_WR |-> !MEM_WDATA[s.bit_idx])
        else $error("Target bit not cleared");

    other_bits_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        MEM_WR |-> (MEM_WDATA | (8'h01 << s.bit_idx))
            == ($past(MEM_RDATA, 2) | (8'h01 << s.bit_idx)))
        else $error("Untargeted bits changed");

    bank_sel_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        (bcf_start_s and acc_bit)
            |=> MEM_ADDR == {$past(BANK_SELECT_REG), $past(f_field)})
        else $error("Banked address wrong");

    access_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        (bcf_start_s and (!acc_bit && (!EXT_EN || f_field > bcf_pkg::BCF_IDX_MAX)))
            |=> MEM_ADDR[7:0] == $past(f_field)
            && MEM_ADDR[11:8] == (($past(f_field) >= bcf_pkg::BCF_ACC_SPLIT)
            ? bcf_pkg::BCF_SFR_BANK : bcf_pkg::BCF_ACC_BANK))
        else $error("Access bank address wrong");

    indexed_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        (bcf_start_s and (!acc_bit && EXT_EN && f_field <= bcf_pkg::BCF_IDX_MAX))
            |=> MEM_ADDR == $past(INDEX_BASE) + {4'h0, $past(f_field)})
        else $error("Indexed address wrong");
endmodule
`default_nettype wire

// [verilog/bcf_pkg.sv]
package bcf_pkg;
    localparam logic [3:0] BCF_OPC = 4'h9;
    localparam int BCF_OPC_MSB = 15;
    localparam int BCF_BIT_LSB = 9;
    localparam int BCF_ACC_POS = 8;
    localparam logic [7:0] BCF_IDX_MAX = 8'h5F;
    // Access bank addresses from 0x60 up map to special function registers in bank F
    localparam logic [7:0] BCF_ACC_SPLIT = 8'h60;
    localparam logic [3:0] BCF_SFR_BANK = 4'hF;
    localparam logic [3:0] BCF_ACC_BANK = 4'h0;
    localparam logic [11:0] BCF_ADDR_RST = 12'h000;
    localparam logic [7:0] BCF_DATA_RST = 8'h00;
    typedef enum logic [3:0] {
        BCF_Q1 = 4'b0001,
        BCF_Q2 = 4'b0010,
        BCF_Q3 = 4'b0100,
        BCF_Q4 = 4'b1000
    } bcf_phase_t;
endpackage
